// *** src/port_pkg.sv ***
/*
 * Shared constants for the timed I/O port, its serialiser and the clock block.
 * Assumes a single 125 MHz system clock with a synchronous active-high reset.
 */
package port_pkg;
	localparam int          CLOCK_MHZ      = 125;
	localparam int          REF_MHZ        = 100;
	localparam int          NUM_CLK_BLOCKS = 6;
	localparam int          CB_SEL_W       = 3;
	localparam logic [2:0]  CB_REF         = 3'h0;
	localparam int          COUNT_W        = 16;
	localparam logic [15:0] COUNT_RESET    = 16'h0000;
	localparam logic [15:0] COUNT_ONE      = 16'h0001;
	localparam int          DIV_W          = 8;
	localparam logic [7:0]  DIV_RESET      = 8'h00;
	localparam logic [7:0]  DIV_STEP       = 8'h01;
	// Reference phase accumulator: adds REF_MHZ per system clock, wraps at CLOCK_MHZ
	localparam int          ACC_W          = 8;
	localparam logic [7:0]  ACC_STEP       = 8'(REF_MHZ);
	localparam logic [7:0]  ACC_WRAP       = 8'(CLOCK_MHZ);
	localparam logic [7:0]  ACC_RESET      = 8'h00;

	typedef enum logic [1:0] {
		MODE_PLAIN  = 2'b00,
		MODE_TIMED  = 2'b01,
		MODE_COND   = 2'b10,
		MODE_STROBE = 2'b11
	} port_mode_t;

	typedef enum logic [1:0] {
		COND_NONE = 2'b00,
		COND_EQ   = 2'b01,
		COND_NEQ  = 2'b10
	} pin_cond_t;

	function automatic logic legal_width(input int w);
		return (w == 1) || (w == 4) || (w == 8) || (w == 16) || (w == 32);
	endfunction
endpackage

// *** src/clock_block.sv ***
/*
 * Six clock blocks: block 0 ticks at the reference rate, the rest
 * divide the reference or a one-bit port input.
 * Assumes pin inputs are synchronous to clock.
 */
`timescale 1ns/10ps
module clock_block
	import port_pkg::*;
(
	input  wire logic                                clock,
	input  wire logic                                srst,
	input  wire logic [NUM_CLK_BLOCKS-1:0]           use_pin,
	input  wire logic [NUM_CLK_BLOCKS-1:0]           pin_clk,
	input  wire logic [NUM_CLK_BLOCKS-1:0][DIV_W-1:0] divide,
	output logic      [NUM_CLK_BLOCKS-1:0]           tick
);
	logic [ACC_W-1:0]                  acc;
	logic [ACC_W-1:0]                  next_acc;
	logic                              ref_tick;
	logic [NUM_CLK_BLOCKS-1:0]         pin_prev;
	logic [DIV_W-1:0]                  div_cnt [NUM_CLK_BLOCKS];
	logic [NUM_CLK_BLOCKS-1:0]         src_tick;

	// Fractional accumulator gives 100 ticks per 125 clocks on average
	assign next_acc = acc + ACC_STEP;
	assign ref_tick = (next_acc >= ACC_WRAP);

	always_ff @(posedge clock) begin
		if (srst) begin
			acc      <= ACC_RESET;
			pin_prev <= '0;
		end else begin
			acc      <= ref_tick ? next_acc - ACC_WRAP : next_acc;
			pin_prev <= pin_clk;
		end
	end

	for (genvar i = 0; i < NUM_CLK_BLOCKS; i++) begin : g_cb
		// Rising edge of the external clock, taken from a one-bit port
		assign src_tick[i] = use_pin[i] ? (pin_clk[i] & ~pin_prev[i]) : ref_tick; // RULE_14
		if (i == 0) begin : g_ref
			assign tick[i] = ref_tick; // RULE_13
			always_ff @(posedge clock) div_cnt[i] <= DIV_RESET;
		end else begin : g_div
			// Divide value 0 passes every source edge
			assign tick[i] = src_tick[i] && (div_cnt[i] == divide[i]); // RULE_15
			always_ff @(posedge clock) begin
				if (srst || tick[i])
					div_cnt[i] <= DIV_RESET;
				else if (src_tick[i])
					div_cnt[i] <= div_cnt[i] + DIV_STEP;
			end
		end
	end

	// Sampled srst keeps the release edge out, where acc is still clear
	ref_rate_a: assert property (@(posedge clock) disable iff (srst) // RULE_13
		!tick[0] && !srst |=> tick[0]) else $error("reference tick missed twice");
	div_hold_a: assert property (@(posedge clock) disable iff (srst) // RULE_15
		tick[1] && divide[1] != DIV_RESET |=> !tick[1])
		else $error("divided tick on consecutive cycles");
endmodule // clock_block

// *** src/serdes_buf.sv ***
/*
 * Shift register plus transfer register between pins and core.
 * Assumes the caller strobes shift on clock-block ticks only.
 */
`timescale 1ns/10ps
module serdes_buf
	import port_pkg::*;
#(
	parameter int WIDTH = 1
) (
	input  wire logic             clock,
	input  wire logic             srst,
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] load_data,
	input  wire logic             capture,
	input  wire logic [WIDTH-1:0] pins,
	output logic      [WIDTH-1:0] shift_q,
	output logic      [WIDTH-1:0] xfer_q
);
	// Transfer register meets the core and samples input pins; shift stage drives the output pins
	always_ff @(posedge clock) begin
		if (srst) begin
			shift_q <= '0;
			xfer_q  <= '0;
		end else begin
			if (load)
				shift_q <= load_data; // RULE_05
			if (capture)
				xfer_q <= pins; // RULE_05
		end
	end
endmodule // serdes_buf

// *** src/timed_port.sv ***
/*
 * One timed I/O port: direction-fixed pins, 16-bit counter, timestamp,
 * conditional input, open-drain and strobe handshakes, pin sharing.
 * Assumes the core issues one request per cycle and pins are synchronous.
 */
// What this block does
// RULE_01: All pins of a port share direction
// RULE_02: Width one, four, eight, sixteen, thirty-two
// RULE_03: Drive or sample, optionally wait condition
// RULE_04: Open-drain: zero pulls low, one floats
// RULE_05: Data passes serialiser and transfer register; input pins are captured straight into the transfer register
// RULE_06: Sixteen-bit counter schedules data transfer
// RULE_07: Counter readable at any time
// RULE_08: Transfer latches counter as timestamp
// RULE_09: Enabled link disconnects underlying port pins
// RULE_10: Enabled port overrules wider sharing port
// RULE_11: Unshared pins stay with wider port
// RULE_12: Transfer always at full width
// RULE_13: Six clock blocks; block zero reference
// RULE_14: Clock block may source one-bit port
// RULE_15: Port-sourced clock may be divided
// RULE_16: External strobe_in marks valid input data
// RULE_17: Strobed output emits strobe_out with data
// RULE_18: After reset ports use clock block zero
// RULE_19: Core port access completes in one cycle
// RULE_20: Counter increments per tick, wraps
`timescale 1ns/10ps
module timed_port
	import port_pkg::*;
#(
	parameter int WIDTH = 4
) (
	input  wire logic                                 clock,
	input  wire logic                                 srst,
	input  wire logic                                 enable,
	input  wire logic                                 is_output,
	input  wire logic                                 open_drain,
	input  wire port_mode_t                           mode,
	input  wire pin_cond_t                            cond,
	input  wire logic [WIDTH-1:0]                     cond_value,
	input  wire logic [COUNT_W-1:0]                   due_time,
	input  wire logic                                 cb_set,
	input  wire logic [CB_SEL_W-1:0]                  cb_sel_in,
	input  wire logic [NUM_CLK_BLOCKS-1:0]            cb_use_pin,
	input  wire logic [NUM_CLK_BLOCKS-1:0]            cb_pin_clk,
	input  wire logic [NUM_CLK_BLOCKS-1:0][DIV_W-1:0] cb_divide,
	input  wire logic                                 wr_req,
	input  wire logic [WIDTH-1:0]                     wr_data,
	input  wire logic                                 rd_req,
	output logic                                      rd_valid,
	output logic      [WIDTH-1:0]                     rd_data,
	output logic      [COUNT_W-1:0]                   count,
	output logic      [COUNT_W-1:0]                   timestamp,
	output logic                                      busy,
	input  wire logic                                 link_enable,
	input  wire logic [WIDTH-1:0]                     narrow_owned,
	input  wire logic [WIDTH-1:0]                     pin_in,
	output logic      [WIDTH-1:0]                     pin_out,
	output logic      [WIDTH-1:0]                     pin_oe_n,
	input  wire logic                                 strobe_in,
	output logic                                      strobe_out
);

	logic [CB_SEL_W-1:0]       cb_sel;
	logic                      cb_ok;
	logic [NUM_CLK_BLOCKS-1:0] ticks;
	logic                      tick;
	logic                      pending;
	logic                      have_data;
	logic                      strobe_q;
	logic [WIDTH-1:0]          shift_q;
	logic [WIDTH-1:0]          xfer_q;
	logic [WIDTH-1:0]          owned;
	logic                      cond_ok;
	logic                      time_ok;
	logic                      fire;
	logic                      do_out;
	logic                      do_in;
	logic [WIDTH-1:0]          drive_en;

	clock_block u_cb (
		.clock   (clock),
		.srst    (srst),
		.use_pin (cb_use_pin),
		.pin_clk (cb_pin_clk),
		.divide  (cb_divide),
		.tick    (ticks)
	);

	// Numbers past the last block are ignored, so tick never indexes off the end
	assign cb_ok = (cb_sel_in < CB_SEL_W'(NUM_CLK_BLOCKS)); // RULE_13
	assign tick  = ticks[cb_sel];

	// Pin ownership: a link or a narrower port removes pins, never the width
	assign owned = (enable && !link_enable) ? ~narrow_owned : '0; // RULE_09 RULE_10 RULE_11

	assign cond_ok = (mode != MODE_COND) || (cond == COND_NONE) ||
		((cond == COND_EQ) && (pin_in == cond_value)) ||
		((cond == COND_NEQ) && (pin_in != cond_value)); // RULE_03
	assign time_ok = (mode != MODE_TIMED) || (count == due_time); // RULE_06
	assign fire    = enable && pending && tick && time_ok && cond_ok &&
		((mode != MODE_STROBE) || is_output || strobe_in); // RULE_16

	// Direction is a whole-port property, so only one path can fire
	assign do_out = fire && is_output; // RULE_01
	assign do_in  = fire && !is_output; // RULE_01

	serdes_buf #(.WIDTH(WIDTH)) u_buf (
		.clock     (clock),
		.srst      (srst),
		.load      (do_out),
		.load_data (xfer_q),
		.capture   (do_in || (wr_req && is_output)),
		.pins      (do_in ? pin_in : wr_data), // RULE_12
		.shift_q   (shift_q),
		.xfer_q    (xfer_q)
	);

	always_ff @(posedge clock) begin
		if (srst)
			cb_sel <= CB_REF; // RULE_18
		else if (cb_set && cb_ok)
			cb_sel <= cb_sel_in;
	end

	always_ff @(posedge clock) begin
		if (srst)
			count <= COUNT_RESET;
		else if (tick)
			count <= count + COUNT_ONE; // RULE_20 RULE_07
	end

	always_ff @(posedge clock) begin
		if (srst)
			timestamp <= COUNT_RESET;
		else if (fire)
			timestamp <= count; // RULE_08
	end

	// A new request arms the port; the fire clears it, request wins a tie
	always_ff @(posedge clock) begin
		if (srst)
			pending <= 1'b0;
		else if (wr_req || rd_req)
			pending <= 1'b1;
		else if (fire)
			pending <= 1'b0;
	end

	always_ff @(posedge clock) begin
		if (srst)
			have_data <= 1'b0;
		else if (do_in)
			have_data <= 1'b1;
		else if (rd_req)
			have_data <= 1'b0;
	end

	always_ff @(posedge clock) begin
		if (srst)
			strobe_q <= 1'b0;
		else
			strobe_q <= do_out && (mode == MODE_STROBE); // RULE_17
	end

	// Read answers the same cycle from the transfer register
	assign rd_valid   = rd_req && have_data; // RULE_19
	assign rd_data    = xfer_q;
	assign busy       = pending;
	assign strobe_out = strobe_q;

	// Open-drain only ever drives a low; ones are released
	assign drive_en = (is_output ? owned : '0) & (open_drain ? ~shift_q : '1); // RULE_04
	assign pin_out  = open_drain ? '0 : shift_q; // RULE_03
	assign pin_oe_n = ~drive_en;

	sequence s_fire_out;
		do_out && (mode == MODE_STROBE);
	endsequence
	sequence s_strobe;
		strobe_out && (pin_out == shift_q || open_drain);
	endsequence

	strobe_follows_a: assert property (@(posedge clock) disable iff (srst) // RULE_17
		s_fire_out |=> s_strobe) else $error("strobe_out missing");
	stamp_latch_a: assert property (@(posedge clock) disable iff (srst) // RULE_08
		fire |=> timestamp == $past(count)) else $error("timestamp not latched");
	count_wrap_a: assert property (@(posedge clock) disable iff (srst) // RULE_20
		tick |=> count == $past(count) + COUNT_ONE) else $error("counter did not step");
	count_hold_a: assert property (@(posedge clock) disable iff (srst) // RULE_06
		!tick |=> $stable(count)) else $error("counter moved without tick");
	reset_block_a: assert property (@(posedge clock) // RULE_18
		srst |=> cb_sel == CB_REF) else $error("clock block not zero after reset");
	od_high_a: assert property (@(posedge clock) disable iff (srst) // RULE_04
		open_drain |-> (pin_out == '0) && ((shift_q & ~pin_oe_n) == '0))
		else $error("open-drain drives high");
	link_off_a: assert property (@(posedge clock) disable iff (srst) // RULE_09
		link_enable |-> pin_oe_n == '1) else $error("port drives under link");
	input_dir_a: assert property (@(posedge clock) disable iff (srst) // RULE_01
		!is_output |-> pin_oe_n == '1) else $error("input port drives pins");
	share_a: assert property (@(posedge clock) disable iff (srst) // RULE_10
		(~pin_oe_n & narrow_owned) == '0) else $error("shared pin not yielded");
	timed_a: assert property (@(posedge clock) disable iff (srst) // RULE_06
		fire && mode == MODE_TIMED |=> timestamp == $past(due_time))
		else $error("early timed transfer");
	strobe_gate_a: assert property (@(posedge clock) disable iff (srst) // RULE_16
		do_in && mode == MODE_STROBE |-> strobe_in) else $error("input taken without strobe");
	read_now_a: assert property (@(posedge clock) disable iff (srst) // RULE_19
		rd_req && have_data |-> rd_valid && rd_data == xfer_q) else $error("read not immediate");

	width_legal_a: assert property (@(posedge clock) legal_width(WIDTH)) // RULE_02
		else $error("port width not one of the legal widths");

	// A transfer is one fire edge, then the registered result
	sequence s_in_fire;
		do_in;
	endsequence
	sequence s_out_fire;
		do_out;
	endsequence
	sequence s_request;
		wr_req || rd_req;
	endsequence

	write_lands_a: assert property (@(posedge clock) disable iff (srst) // RULE_19
		wr_req && is_output |=> xfer_q == $past(wr_data))
		else $error("write did not reach transfer register");
	capture_full_a: assert property (@(posedge clock) disable iff (srst) // RULE_12
		s_in_fire |=> xfer_q == $past(pin_in))
		else $error("input not captured at full width");
	load_shift_a: assert property (@(posedge clock) disable iff (srst) // RULE_05
		s_out_fire |=> shift_q == $past(xfer_q))
		else $error("output not moved to shift stage");
	out_hold_a: assert property (@(posedge clock) disable iff (srst) // RULE_05
		!do_out |=> $stable(shift_q))
		else $error("pin value changed without transfer");
	in_hold_a: assert property (@(posedge clock) disable iff (srst) // RULE_05
		!do_in && !(wr_req && is_output) |=> $stable(xfer_q))
		else $error("transfer register changed without cause");

	idle_a: assert property (@(posedge clock) disable iff (srst) // RULE_03
		!enable |=> $stable(timestamp) && $stable(shift_q))
		else $error("disabled port transferred");
	busy_arm_a: assert property (@(posedge clock) disable iff (srst) // RULE_19
		s_request |=> busy)
		else $error("request did not arm port");
	busy_clear_a: assert property (@(posedge clock) disable iff (srst) // RULE_06
		fire && !wr_req && !rd_req |=> !busy)
		else $error("transfer left port busy");
	pend_hold_a: assert property (@(posedge clock) disable iff (srst) // RULE_06
		!fire && !wr_req && !rd_req |=> $stable(busy))
		else $error("busy changed without cause");
	data_flag_a: assert property (@(posedge clock) disable iff (srst) // RULE_19
		s_in_fire |=> have_data)
		else $error("captured data not flagged");
	read_clears_a: assert property (@(posedge clock) disable iff (srst) // RULE_19
		rd_req && !do_in |=> !have_data)
		else $error("read left data flagged");
	read_refuse_a: assert property (@(posedge clock) disable iff (srst) // RULE_19
		!have_data || !rd_req |-> !rd_valid)
		else $error("read valid without data");

	strobe_once_a: assert property (@(posedge clock) disable iff (srst) // RULE_17
		strobe_out && !do_out |=> !strobe_out)
		else $error("strobe_out held longer than one cycle");
	no_strobe_a: assert property (@(posedge clock) disable iff (srst) // RULE_17
		do_out && mode != MODE_STROBE |=> !strobe_out)
		else $error("strobe_out outside strobed mode");
	out_only_a: assert property (@(posedge clock) disable iff (srst) // RULE_01
		!is_output |-> !do_out)
		else $error("input port moved output data");
	unshared_a: assert property (@(posedge clock) disable iff (srst) // RULE_11
		is_output && enable && !link_enable && !open_drain |-> pin_oe_n == narrow_owned)
		else $error("unshared pin not driven");
	od_low_a: assert property (@(posedge clock) disable iff (srst) // RULE_04
		is_output && enable && !link_enable && open_drain
		|-> pin_oe_n == (shift_q | narrow_owned))
		else $error("open-drain zero not driven low");

	stamp_hold_a: assert property (@(posedge clock) disable iff (srst) // RULE_08
		!fire |=> $stable(timestamp))
		else $error("timestamp moved without transfer");
	stamp_reset_a: assert property (@(posedge clock) // RULE_08
		srst |=> timestamp == COUNT_RESET)
		else $error("timestamp not cleared by reset");
	count_reset_a: assert property (@(posedge clock) // RULE_20
		srst |=> count == COUNT_RESET)
		else $error("counter not cleared by reset");
	timed_hold_a: assert property (@(posedge clock) disable iff (srst) // RULE_06
		mode == MODE_TIMED && count != due_time |-> !fire)
		else $error("timed transfer before due count");
	cb_hold_a: assert property (@(posedge clock) disable iff (srst) // RULE_18
		!cb_set |=> $stable(cb_sel))
		else $error("clock block changed without select");
	cb_legal_a: assert property (@(posedge clock) disable iff (srst) // RULE_13
		cb_sel < CB_SEL_W'(NUM_CLK_BLOCKS))
		else $error("selected clock block does not exist");

	cond_eq_a: assert property (@(posedge clock) disable iff (srst) // RULE_03
		fire && mode == MODE_COND && cond == COND_EQ |-> pin_in == cond_value)
		else $error("equal condition not met at transfer");
	cond_neq_a: assert property (@(posedge clock) disable iff (srst) // RULE_03
		fire && mode == MODE_COND && cond == COND_NEQ |-> pin_in != cond_value)
		else $error("unequal condition not met at transfer");
endmodule // timed_port

// *** bench/ext_hw.sv ***
/*
 * Model of the external hardware at the pins of a four-bit port.
 * Assumes it shares the system clock and drives every pin the port releases.
 */
`timescale 1ns/10ps
module ext_hw (
	input  wire logic       clock,
	input  wire logic [3:0] pin_out,
	input  wire logic [3:0] pin_oe_n,
	input  wire logic [3:0] ext_val,
	input  wire logic       strobe_req,
	output logic      [3:0] pin_in,
	output logic            strobe_in
);
	// Wire level: port value where it drives, our value elsewhere
	assign pin_in = (pin_out & ~pin_oe_n) | (ext_val & pin_oe_n);
	initial strobe_in = 1'b0;
	always @(posedge clock) begin
		strobe_in <= strobe_req;
	end
endmodule // ext_hw

// *** bench/tb_top.sv ***
/*
 * Self-checking bench for one four-bit timed port and its pin partner.
 * Assumes the 125 MHz clock and the package constants of the design.
 */
`timescale 1ns/10ps
module tb_top
	import port_pkg::*;
;
	logic            clock = 1'b0, srst = 1'b1, enable = 1'b0, is_output = 1'b1;
	logic            open_drain = 1'b0, cb_set = 1'b0, wr_req = 1'b0, rd_req = 1'b0;
	logic            link_enable = 1'b0, strobe_req = 1'b0, v, seen;
	port_mode_t      mode = MODE_PLAIN;
	pin_cond_t       cond = COND_NONE;
	logic [3:0]      cond_value = 4'h0, wr_data = 4'h0, narrow_owned = 4'h0, ext_val = 4'h0, d;
	logic [15:0]     due_time = 16'h0000, c0;
	logic [2:0]      cb_sel_in = 3'h0;
	logic [5:0]      cb_use_pin = 6'h00, cb_pin_clk = 6'h00;
	logic [5:0][7:0] cb_divide = 48'h0;
	logic            rd_valid, busy, strobe_in, strobe_out;
	logic [3:0]      rd_data, pin_out, pin_oe_n, pin_in;
	logic [15:0]     count, timestamp;
	int              errors = 0, comparisons = 0;

	always #4 clock = ~clock;

	timed_port #(.WIDTH(4)) dut (.clock(clock), .srst(srst), .enable(enable),
		.is_output(is_output), .open_drain(open_drain), .mode(mode), .cond(cond),
		.cond_value(cond_value), .due_time(due_time), .cb_set(cb_set), .cb_sel_in(cb_sel_in),
		.cb_use_pin(cb_use_pin), .cb_pin_clk(cb_pin_clk), .cb_divide(cb_divide),
		.wr_req(wr_req), .wr_data(wr_data), .rd_req(rd_req), .rd_valid(rd_valid),
		.rd_data(rd_data), .count(count), .timestamp(timestamp), .busy(busy),
		.link_enable(link_enable), .narrow_owned(narrow_owned), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe_n(pin_oe_n), .strobe_in(strobe_in),
		.strobe_out(strobe_out));
	ext_hw ext (.clock(clock), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_val(ext_val),
		.strobe_req(strobe_req), .pin_in(pin_in), .strobe_in(strobe_in));

	task automatic end_of_test;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t got %0h expected %0h", $time, got, exp);
		end
	endtask

	// Land just after the edge so registered outputs have settled
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task automatic wait_idle;
		for (int i = 0; i < 400 && busy !== 1'b0; i++)
			tick(1);
		seen = strobe_out;
		check({15'h0000, busy}, 16'h0000);
	endtask

	task automatic put(input logic [3:0] x);
		@(posedge clock) wr_req <= 1'b1;
		wr_data <= x;
		@(posedge clock) wr_req <= 1'b0;
		#1;
		wait_idle();
	endtask

	task automatic get;
		@(posedge clock) rd_req <= 1'b1;
		#1;
		v = rd_valid;
		d = rd_data;
		@(posedge clock) rd_req <= 1'b0;
		#1;
	endtask

	// Arm an input, hold the gating condition off, then let it through
	task automatic in_case(input port_mode_t m, input pin_cond_t c, input logic [3:0] hold,
		input logic [3:0] val);
		@(posedge clock) mode <= m;
		cond <= c;
		cond_value <= 4'h6;
		ext_val <= hold;
		get();
		tick(30);
		check({15'h0000, busy}, 16'h0001);
		@(posedge clock) ext_val <= val;
		strobe_req <= (m == MODE_STROBE);
		// Two cycles so the strobe cannot fall between reference ticks
		repeat (2) @(posedge clock);
		strobe_req <= 1'b0;
		#1;
		wait_idle();
		get();
		check({15'h0000, v}, 16'h0001);
		check({12'h000, d}, {12'h000, val});
	endtask

	initial begin
		#(8 * 20000);
		errors++;
		end_of_test();
	end

	initial begin
		repeat (20) @(posedge clock);
		srst <= 1'b0;
		#1;
		check(count, COUNT_RESET);
		check(timestamp, COUNT_RESET);
		check({12'h000, pin_oe_n}, 16'h000F);
		@(posedge clock) enable <= 1'b1;
		#1;
		c0 = count;
		tick(125);
		check(count - c0, 16'h0064);
		put(4'hA);
		check({12'h000, pin_out}, 16'h000A);
		check({12'h000, pin_oe_n}, 16'h0000);
		@(posedge clock) mode <= MODE_TIMED;
		due_time <= count + 16'h0020;
		put(4'h3);
		check(timestamp, due_time);
		@(posedge clock) mode <= MODE_STROBE;
		open_drain <= 1'b1;
		put(4'h5);
		check({15'h0000, seen}, 16'h0001);
		check({12'h000, pin_oe_n}, 16'h0005);
		tick(1);
		check({15'h0000, strobe_out}, 16'h0000);
		@(posedge clock) open_drain <= 1'b0;
		narrow_owned <= 4'h3;
		tick(2);
		check({12'h000, pin_oe_n}, 16'h0003);
		check({12'h000, pin_out}, 16'h0005);
		@(posedge clock) link_enable <= 1'b1;
		tick(2);
		check({12'h000, pin_oe_n}, 16'h000F);
		@(posedge clock) link_enable <= 1'b0;
		narrow_owned <= 4'h0;
		is_output <= 1'b0;
		tick(2);
		check({12'h000, pin_oe_n}, 16'h000F);
		in_case(MODE_COND, COND_EQ, 4'h3, 4'h6);
		in_case(MODE_COND, COND_NEQ, 4'h6, 4'hE);
		in_case(MODE_STROBE, COND_NONE, 4'h7, 4'h7);
		@(posedge clock) cb_use_pin <= 6'h02;
		cb_divide[1] <= 8'h01;
		cb_sel_in <= 3'h1;
		cb_set <= 1'b1;
		@(posedge clock) cb_set <= 1'b0;
		tick(4);
		c0 = count;
		repeat (8) begin
			@(posedge clock) cb_pin_clk <= 6'h02;
			repeat (3) @(posedge clock);
			cb_pin_clk <= 6'h00;
			repeat (3) @(posedge clock);
		end
		tick(4);
		check(count - c0, 16'h0004);
		end_of_test();
	end
endmodule // tb_top
